// *** src/rf_pwr_pkg.sv ***
// Behaviour
// R1: pump bit 0 resets 1, clear forces on
// R2: rx path power-down register at 0x2204
// R3: bit 7 amplifier down; pair decodes modem/up/down
// R4: bit 6 mixer down; decodes like the amplifier
// R5: decoded mixer power-down disables the mixer
// R6: pump bit sits in pll register 0x2203
// R7: modem mode enable follows modem request
package rf_pwr_pkg;

   // register indices; byte address is four times the index
   localparam int IDX_PLL_PD = 32'h0000_2202;
   localparam int IDX_PLL_PU = 32'h0000_2203;
   localparam int IDX_RX_PD  = 32'h0000_2204;
   localparam int IDX_RX_PU  = 32'h0000_2205;
   localparam int IDX_STATUS = 32'h0000_2206;
   localparam int ADDR_W     = 16;
   localparam int BYTES_PER_WORD = 4;

   // byte addresses on the register bus
   localparam logic [ADDR_W-1:0] PLL_PD_ADDR = 16'(IDX_PLL_PD * BYTES_PER_WORD);
   localparam logic [ADDR_W-1:0] PLL_PU_ADDR = 16'(IDX_PLL_PU * BYTES_PER_WORD);
   localparam logic [ADDR_W-1:0] RX_PD_ADDR  = 16'(IDX_RX_PD * BYTES_PER_WORD);
   localparam logic [ADDR_W-1:0] RX_PU_ADDR  = 16'(IDX_RX_PU * BYTES_PER_WORD);
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'(IDX_STATUS * BYTES_PER_WORD);

   // field positions
   localparam int PUMP_BIT    = 0;
   localparam int DIV_BIT     = 1;
   localparam int VCO_BIT     = 2;
   localparam int VCOBUF_BIT  = 3;
   localparam int PLL_RST_BIT = 4;
   localparam int MIXBUF_BIT  = 4;
   localparam int BBAMP_BIT   = 5;
   localparam int MIX_BIT     = 6;
   localparam int LNA_BIT     = 7;
   localparam int RX_LSB      = 4;
   localparam int N_PLL       = 4;
   localparam int N_RX        = 4;
   localparam int PLL_PU_W    = 5;

   // reset values
   localparam logic [7:0]          PLL_PD_RST  = 8'h0f;
   localparam logic [PLL_PU_W-1:0] PLL_PU_RST  = 5'h1f;
   localparam logic [2:0]          PLL_PU_RSVD = 3'h7;
   localparam logic [7:0]          RX_PD_RST   = 8'h00;
   localparam logic [7:0]          RX_PU_RST   = 8'h00;

   // power-down / power-up pair encodings
   typedef enum logic [1:0]
   {
      MODE_MODEM   = 2'b11,
      MODE_UP_HI   = 2'b10,
      MODE_DOWN    = 2'b01,
      MODE_UP_LO   = 2'b00
   } pwr_mode_t;

   // circuit enable from a down/up pair and the modem request
   function automatic logic decode_enable(input logic down_bit,
                                          input logic up_bit,
                                          input logic modem_req);
      pwr_mode_t mode;
      mode = pwr_mode_t'({down_bit, up_bit});
      case (mode)
         MODE_MODEM: return modem_req;
         MODE_DOWN:  return 1'b0;
         MODE_UP_HI: return 1'b1;
         MODE_UP_LO: return 1'b1;
         default:    return 1'b1;
      endcase
   endfunction

endpackage

// *** src/pwr_decode_cell.sv ***
module pwr_decode_cell (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control pair and modem request
   input  wire logic down_bit,
   input  wire logic up_bit,
   input  wire logic modem_req,
   // registered circuit enable
   output logic      en_q
);

   // enable flop: forced state or modem request, one cycle late
   always_ff @(posedge clk)
   begin
      if (rst)
         en_q <= 1'b0;
      else
         en_q <= rf_pwr_pkg::decode_enable(down_bit, up_bit, modem_req); // [R3] [R5] [R7]
   end

endmodule

// *** src/rf_rx_power_override_ctl.sv ***
module rf_rx_power_override_ctl (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // avalon-mm slave
   input  wire logic [rf_pwr_pkg::ADDR_W-1:0] address,
   input  wire logic                          read,
   input  wire logic                          write,
   input  wire logic [31:0]                   writedata,
   input  wire logic [3:0]                    byteenable,
   output logic      [31:0]                   readdata,
   output logic                               waitrequest,
   // modem power requests
   input  wire logic [3:0]                    modem_pll_req,
   input  wire logic [3:0]                    modem_rx_req,
   // circuit enables and pll reset
   output logic      [3:0]                    pll_en,
   output logic      [3:0]                    rx_en,
   output logic                               pll_reset
);

   logic [7:0]                      pll_pd_q;
   logic [rf_pwr_pkg::PLL_PU_W-1:0] pll_pu_q;
   logic [7:0]                      rx_pd_q;
   logic [7:0]                      rx_pu_q;
   logic [7:0]                      rd_mux;
   logic                            req;
   logic                            wr_take;
   logic [3:0]                      pll_modem_mask;
   logic [3:0]                      rx_modem_mask;
   logic                            mix_forced_down;
   logic                            mix_forced_up;
   logic [1:0]                      lna_pair;
   logic [1:0]                      mix_pair;
   logic [1:0]                      pump_pair;

   // request present and write commit strobe
   assign req     = read | write;
   assign wr_take = write & ~waitrequest & byteenable[0];

   // waitrequest drops for one cycle after each new request
   always_ff @(posedge clk)
   begin
      if (rst)
         waitrequest <= 1'b1;
      else
         waitrequest <= ~(req & waitrequest);
   end

   // read data multiplexer; unmapped addresses read zero
   always_comb
   begin
      rd_mux = 8'h00;
      case (address)
         rf_pwr_pkg::PLL_PD_ADDR: rd_mux = pll_pd_q;
         rf_pwr_pkg::PLL_PU_ADDR: rd_mux = {rf_pwr_pkg::PLL_PU_RSVD, pll_pu_q}; // [R6]
         rf_pwr_pkg::RX_PD_ADDR:  rd_mux = rx_pd_q;                             // [R2]
         rf_pwr_pkg::RX_PU_ADDR:  rd_mux = rx_pu_q;
         rf_pwr_pkg::STATUS_ADDR: rd_mux = {rx_en, pll_en};
         default:                 rd_mux = 8'h00;
      endcase
   end

   // read data captured while waitrequest is still high
   always_ff @(posedge clk)
   begin
      if (rst)
         readdata <= 32'h0000_0000;
      else if (read & waitrequest)
         readdata <= {24'h00_0000, rd_mux};
   end

   // pll power-down register
   always_ff @(posedge clk)
   begin
      if (rst)
         pll_pd_q <= rf_pwr_pkg::PLL_PD_RST;
      else if (wr_take && address == rf_pwr_pkg::PLL_PD_ADDR)
         pll_pd_q <= writedata[7:0];
   end

   // pll power-up register; top bits reserved and fixed
   always_ff @(posedge clk)
   begin
      if (rst)
         pll_pu_q <= rf_pwr_pkg::PLL_PU_RST;                         // [R1]
      else if (wr_take && address == rf_pwr_pkg::PLL_PU_ADDR)         // [R6]
         pll_pu_q <= writedata[rf_pwr_pkg::PLL_PU_W-1:0];
   end

   // rx path power-down register
   always_ff @(posedge clk)
   begin
      if (rst)
         rx_pd_q <= rf_pwr_pkg::RX_PD_RST;                            // [R3] [R4]
      else if (wr_take && address == rf_pwr_pkg::RX_PD_ADDR)          // [R2]
         rx_pd_q <= writedata[7:0];
   end

   // rx path power-up register
   always_ff @(posedge clk)
   begin
      if (rst)
         rx_pu_q <= rf_pwr_pkg::RX_PU_RST;
      else if (wr_take && address == rf_pwr_pkg::RX_PU_ADDR)
         rx_pu_q <= writedata[7:0];
   end

   // pll reset held while its clear bit is one
   always_ff @(posedge clk)
   begin
      if (rst)
         pll_reset <= 1'b1;
      else
         pll_reset <= pll_pu_q[rf_pwr_pkg::PLL_RST_BIT];
   end

   // pll circuits: pump, divider, oscillator, oscillator buffer
   generate
      for (genvar i = 0; i < rf_pwr_pkg::N_PLL; i++)
      begin : g_pll
         pwr_decode_cell u_cell (
            .clk       (clk),
            .rst       (rst),
            .down_bit  (pll_pd_q[i]),
            .up_bit    (pll_pu_q[i]),   // [R1]
            .modem_req (modem_pll_req[i]),
            .en_q      (pll_en[i])
         );
      end
   endgenerate

   // rx circuits: mixer buffer, baseband amp, mixer, amplifier
   generate
      for (genvar j = 0; j < rf_pwr_pkg::N_RX; j++)
      begin : g_rx
         pwr_decode_cell u_cell (
            .clk       (clk),
            .rst       (rst),
            .down_bit  (rx_pd_q[rf_pwr_pkg::RX_LSB + j]),   // [R3] [R4]
            .up_bit    (rx_pu_q[rf_pwr_pkg::RX_LSB + j]),
            .modem_req (modem_rx_req[j]),
            .en_q      (rx_en[j])
         );
      end
   endgenerate

   // helper terms read only by the checks below
   assign pll_modem_mask  = pll_pd_q[3:0] & pll_pu_q[3:0];
   assign rx_modem_mask   = rx_pd_q[7:4] & rx_pu_q[7:4];
   assign mix_forced_down = ~rx_pd_q[rf_pwr_pkg::MIX_BIT] & rx_pu_q[rf_pwr_pkg::MIX_BIT];
   assign mix_forced_up   = rx_pd_q[rf_pwr_pkg::MIX_BIT] & ~rx_pu_q[rf_pwr_pkg::MIX_BIT];
   assign lna_pair        = {rx_pd_q[rf_pwr_pkg::LNA_BIT], rx_pu_q[rf_pwr_pkg::LNA_BIT]};
   assign mix_pair        = {rx_pd_q[rf_pwr_pkg::MIX_BIT], rx_pu_q[rf_pwr_pkg::MIX_BIT]};
   assign pump_pair       = {pll_pd_q[rf_pwr_pkg::PUMP_BIT], pll_pu_q[rf_pwr_pkg::PUMP_BIT]};

   // pump held on whenever its power-up bit was zero
   property p_pump_forced_up;
      @(posedge clk) disable iff (rst)
      (!$past(rst) && !$past(pll_pu_q[rf_pwr_pkg::PUMP_BIT]))
         |-> pll_en[rf_pwr_pkg::PUMP_BIT];
   endproperty
   a_pump_forced_up: assert property (p_pump_forced_up) // [R1]
      else $error("pump not powered up with its up bit clear");

   // rx power-down register reads back what was stored
   property p_rx_pd_readback;
      @(posedge clk) disable iff (rst)
      (read && !waitrequest && address == rf_pwr_pkg::RX_PD_ADDR)
         |-> readdata == {24'h00_0000, rx_pd_q};
   endproperty
   a_rx_pd_readback: assert property (p_rx_pd_readback) // [R2]
      else $error("rx power-down register read mismatch");

   // amplifier enable follows the truth table one cycle on
   property p_lna_decode;
      @(posedge clk) disable iff (rst)
      !$past(rst) |-> rx_en[rf_pwr_pkg::LNA_BIT - rf_pwr_pkg::RX_LSB]
         == (($past(lna_pair) == rf_pwr_pkg::MODE_MODEM)
             ? $past(modem_rx_req[rf_pwr_pkg::LNA_BIT - rf_pwr_pkg::RX_LSB])
             : ($past(lna_pair) != rf_pwr_pkg::MODE_DOWN));
   endproperty
   a_lna_decode: assert property (p_lna_decode) // [R3]
      else $error("amplifier enable does not match its decode");

   // mixer forced up stays on for as long as the pair holds
   property p_mix_forced_up;
      @(posedge clk) disable iff (rst)
      (mix_forced_up [*2]) |-> rx_en[rf_pwr_pkg::MIX_BIT - rf_pwr_pkg::RX_LSB];
   endproperty
   a_mix_forced_up: assert property (p_mix_forced_up) // [R4]
      else $error("mixer not powered up while forced up");

   // mixer disabled in the cycle after a decoded power-down
   property p_mix_off;
      @(posedge clk) disable iff (rst)
      (!$past(rst) && $past(mix_forced_down))
         |-> !rx_en[rf_pwr_pkg::MIX_BIT - rf_pwr_pkg::RX_LSB];
   endproperty
   a_mix_off: assert property (p_mix_off) // [R5]
      else $error("mixer enabled while decoded power-down");

   // pll register reads reserved ones above the five fields
   property p_pll_pu_readback;
      @(posedge clk) disable iff (rst)
      (read && !waitrequest && address == rf_pwr_pkg::PLL_PU_ADDR)
         |-> (readdata[7:5] == rf_pwr_pkg::PLL_PU_RSVD
              && readdata[rf_pwr_pkg::PLL_PU_W-1:0] == pll_pu_q);
   endproperty
   a_pll_pu_readback: assert property (p_pll_pu_readback) // [R6]
      else $error("pll power-up register read mismatch");

   // modem-controlled circuits follow their requests
   property p_modem_follow;
      @(posedge clk) disable iff (rst)
      !$past(rst) |->
         ((pll_en & $past(pll_modem_mask)) == ($past(modem_pll_req) & $past(pll_modem_mask)))
         && ((rx_en & $past(rx_modem_mask)) == ($past(modem_rx_req) & $past(rx_modem_mask)));
   endproperty
   a_modem_follow: assert property (p_modem_follow) // [R7]
      else $error("modem-controlled enable ignored its request");

   // every request answered in the cycle after it is seen
   property p_bus_answer;
      @(posedge clk) disable iff (rst)
      (req && waitrequest) |=> !waitrequest ##1 waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("waitrequest did not answer in one cycle");

   // writes to the rx power-down register land on the next cycle
   property p_rx_pd_write;
      @(posedge clk) disable iff (rst)
      (wr_take && address == rf_pwr_pkg::RX_PD_ADDR)
         |=> rx_pd_q == $past(writedata[7:0]);
   endproperty
   a_rx_pd_write: assert property (p_rx_pd_write) // [R2]
      else $error("rx power-down write not stored");

   // mixer enable follows the truth table one cycle on
   property p_mix_decode;
      @(posedge clk) disable iff (rst)
      !$past(rst) |-> rx_en[rf_pwr_pkg::MIX_BIT - rf_pwr_pkg::RX_LSB]
         == (($past(mix_pair) == rf_pwr_pkg::MODE_MODEM)
             ? $past(modem_rx_req[rf_pwr_pkg::MIX_BIT - rf_pwr_pkg::RX_LSB])
             : ($past(mix_pair) != rf_pwr_pkg::MODE_DOWN));
   endproperty
   a_mix_decode: assert property (p_mix_decode) // [R4] [R5]
      else $error("mixer enable does not match its pair");

   // pump enable follows the truth table one cycle on
   property p_pump_decode;
      @(posedge clk) disable iff (rst)
      !$past(rst) |-> pll_en[rf_pwr_pkg::PUMP_BIT]
         == (($past(pump_pair) == rf_pwr_pkg::MODE_MODEM)
             ? $past(modem_pll_req[rf_pwr_pkg::PUMP_BIT])
             : ($past(pump_pair) != rf_pwr_pkg::MODE_DOWN));
   endproperty
   a_pump_decode: assert property (p_pump_decode) // [R1]
      else $error("pump enable does not match its pair");

   // pll reset mirrors its stored clear bit one cycle on
   property p_pll_reset_follow;
      @(posedge clk) disable iff (rst)
      !$past(rst) |-> pll_reset == $past(pll_pu_q[rf_pwr_pkg::PLL_RST_BIT]);
   endproperty
   a_pll_reset_follow: assert property (p_pll_reset_follow) // [R6]
      else $error("pll reset does not follow its clear bit");

   // a write with the low byte lane off leaves the registers alone
   property p_masked_write;
      @(posedge clk) disable iff (rst)
      (write && !waitrequest && !byteenable[0])
         |=> $stable(rx_pd_q) && $stable(rx_pu_q)
             && $stable(pll_pd_q) && $stable(pll_pu_q);
   endproperty
   a_masked_write: assert property (p_masked_write) // [R2]
      else $error("masked write changed a register");

   // status word reads the enables as they stood when the read was taken
   property p_status_readback;
      @(posedge clk) disable iff (rst)
      (!$past(rst) && read && !waitrequest && address == rf_pwr_pkg::STATUS_ADDR)
         |-> readdata == {24'h00_0000, $past(rx_en), $past(pll_en)};
   endproperty
   a_status_readback: assert property (p_status_readback) // [R7]
      else $error("status register read mismatch");

   // waitrequest stays high while no request is seen
   property p_idle_wait;
      @(posedge clk) disable iff (rst)
      (!$past(rst) && !$past(req)) |-> waitrequest;
   endproperty
   a_idle_wait: assert property (p_idle_wait)
      else $error("waitrequest low without a request");

   // amplifier under modem control toggles
   c_lna_modem: cover property (@(posedge clk) disable iff (rst)
      rx_modem_mask[3] && rx_en[3] ##1 rx_modem_mask[3] && !rx_en[3]);

   // mixer forced down after being on
   c_mix_down: cover property (@(posedge clk) disable iff (rst)
      rx_en[2] ##1 mix_forced_down ##1 !rx_en[2]);

   // pump forced up by clearing its up bit
   c_pump_up: cover property (@(posedge clk) disable iff (rst)
      !pll_pu_q[rf_pwr_pkg::PUMP_BIT] ##1 pll_en[rf_pwr_pkg::PUMP_BIT]);

   // a register write accepted
   c_write: cover property (@(posedge clk) disable iff (rst)
      write && !waitrequest);

   // the status word read back
   c_status_read: cover property (@(posedge clk) disable iff (rst)
      read && !waitrequest && address == rf_pwr_pkg::STATUS_ADDR);

endmodule

// *** tb/modem_model.sv ***
module modem_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // requests the bench wants the modem to make
   input  wire logic [3:0] pll_cmd,
   input  wire logic [3:0] rx_cmd,
   // power requests toward the block
   output logic      [3:0] pll_req,
   output logic      [3:0] rx_req
);
   timeunit 1ns;
   timeprecision 1ps;

   // requests launched from the clock edge, quiet while in reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pll_req <= 4'h0;
         rx_req  <= 4'h0;
      end
      else
      begin
         pll_req <= pll_cmd;
         rx_req  <= rx_cmd;
      end
   end
endmodule

// *** tb/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rst, read, write, waitrequest, pll_reset, d, u, e;
   logic [15:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [3:0]  byteenable, pll_req, rx_req, pll_en, rx_en, pll_cmd, rx_cmd;
   logic [7:0]  pat;
   int          miscompares, cmp_count, cycles;

   rf_rx_power_override_ctl u_rf_rx_power_override_ctl (.clk(clk), .rst(rst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .modem_pll_req(pll_req), .modem_rx_req(rx_req), .pll_en(pll_en),
      .rx_en(rx_en), .pll_reset(pll_reset));

   modem_model u_modem_model (.clk(clk), .rst(rst), .pll_cmd(pll_cmd),
      .rx_cmd(rx_cmd), .pll_req(pll_req), .rx_req(rx_req));

   // free-running system clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until waitrequest is sampled low, then released
   task automatic bus_write(input logic [15:0] a, input logic [7:0] v, input logic [3:0] be);
      @(posedge clk);
      address    <= a;
      writedata  <= {24'h0, v};
      byteenable <= be;
      write      <= 1'b1;
      do
         @(posedge clk);
      while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask

   // only the hang guard ends a wait that never gets its answer
   task automatic bus_read(input logic [15:0] a, output logic [31:0] v);
      @(posedge clk);
      address <= a;
      read    <= 1'b1;
      do
         @(posedge clk);
      while (waitrequest !== 1'b0);
      v = readdata;
      read <= 1'b0;
   endtask

   // lets a register write reach the registered enables
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   // main sequence
   initial
   begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 16'h0000;
      writedata = 32'h0000_0000;
      byteenable = 4'h1;
      pll_cmd = 4'h0;
      rx_cmd = 4'h0;
      pat = 8'hb2;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk(32'(rx_en), 32'h0000_000f);
      chk(32'(pll_en), 32'h0000_0000);
      chk(32'(pll_reset), 32'h0000_0001);
      bus_read(rf_pwr_pkg::RX_PD_ADDR, rd);
      chk(rd, 32'h0000_0000);
      bus_read(rf_pwr_pkg::PLL_PU_ADDR, rd);
      chk(rd, 32'h0000_00ff);
      bus_read(rf_pwr_pkg::STATUS_ADDR, rd);
      chk(rd, 32'h0000_00f0);
      $display("test reset done");
      // every down/up pair against both modem request levels
      for (int m = 0; m < 4; m++)
      begin
         for (int r = 0; r < 2; r++)
         begin
            d = m[1];
            u = m[0];
            e = (d & u) ? r[0] : ~(~d & u);
            bus_write(rf_pwr_pkg::RX_PD_ADDR, {d, d, 6'h00}, 4'h1);
            bus_write(rf_pwr_pkg::RX_PU_ADDR, {u, u, 6'h00}, 4'h1);
            bus_write(rf_pwr_pkg::PLL_PD_ADDR, {7'h07, d}, 4'h1);
            bus_write(rf_pwr_pkg::PLL_PU_ADDR, {7'h0f, u}, 4'h1);
            pll_cmd <= {4{r[0]}};
            rx_cmd <= {4{r[0]}};
            settle();
            chk(32'(rx_en), 32'({e, e, 2'b11}));
            chk(32'(pll_en), 32'({r[0], r[0], r[0], e}));
            bus_read(rf_pwr_pkg::RX_PD_ADDR, rd);
            chk(rd, 32'({d, d, 6'h00}));
         end
      end
      $display("test decode done");
      // release of the pll reset through bit 4
      bus_write(rf_pwr_pkg::PLL_PU_ADDR, 8'h0f, 4'h1);
      settle();
      chk(32'(pll_reset), 32'h0000_0000);
      bus_read(rf_pwr_pkg::PLL_PU_ADDR, rd);
      chk(rd, 32'h0000_00ef);
      // masked lane and unmapped address leave the registers alone
      bus_write(rf_pwr_pkg::RX_PD_ADDR, 8'h40, 4'h0);
      bus_write(16'h0010, 8'h55, 4'h1);
      bus_read(16'h0010, rd);
      chk(rd, 32'h0000_0000);
      bus_read(rf_pwr_pkg::RX_PD_ADDR, rd);
      chk(rd, 32'h0000_00c0);
      bus_read(rf_pwr_pkg::RX_PU_ADDR, rd);
      chk(rd, 32'h0000_00c0);
      bus_read(rf_pwr_pkg::PLL_PD_ADDR, rd);
      chk(rd, 32'h0000_000f);
      $display("test refusals done");
      // modem mode tracks a request that takes the next bit of pat each cycle
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         rx_cmd <= {pat[i], pat[i], 2'b00};
         #1;
         if (i >= 2)
            chk(32'(rx_en[3:2]), 32'({pat[i-2], pat[i-2]}));
      end
      $display("test follow done");
      give_verdict();
   end
endmodule
